// ---- rtl/flash_host.sv ----
// Host-side controller driving the asynchronous flash pin interface
`timescale 1ns/10ps

module flash_host
	import flash_host_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reqValid,
	output logic reqReady,
	input wire host_req_t req,
	input wire logic powerDownReq,
	output logic rdValid,
	output logic [DATA_W-1:0] rdData,
	output flash_ctl_t ctl,
	input wire logic [DATA_W-1:0] dqIn,
	output logic [DATA_W-1:0] dqOut,
	output logic [DATA_W-1:0] dqOeN
);

	// ****************************************
	// Reset release and input synchronisers
	// ****************************************
	logic rstMeta_r, rstSync_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end

	// Pin data is asynchronous to clk
	logic [DATA_W-1:0] dqMeta_r, dqSync_r;
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			dqMeta_r <= DATA_RESET;
			dqSync_r <= DATA_RESET;
		end else begin
			dqMeta_r <= dqIn;
			dqSync_r <= dqMeta_r;
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	host_state_t state_r, state_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	host_req_t cur_r;
	logic [DATA_W-1:0] rdData_r;
	logic rdValid_r;

	wire cntDone = (cnt_r == '0);
	wire accept = reqValid && reqReady;

	assign reqReady = (state_r == ST_IDLE) && !powerDownReq;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cntDone ? cnt_r : cnt_r - 8'h01;
		case (state_r)
			ST_RESET: begin
				if (cntDone && !powerDownReq) begin
					// Device needs time to wake after power-down
					state_nxt = ST_RECOVER;
					cnt_nxt = CNT_W'(RECOVERY_CYC - 1);
				end
			end
			ST_RECOVER: begin
				if (cntDone) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (powerDownReq) begin
					state_nxt = ST_RESET;
					cnt_nxt = CNT_W'(RESET_LOW_CYC - 1);
				end else if (accept && req.write) begin
					state_nxt = ST_W_SETUP;
					cnt_nxt = CNT_W'(SETUP_CYC - 1);
				end else if (accept) begin
					state_nxt = ST_R_ACCESS;
					cnt_nxt = CNT_W'(ACCESS_CYC - 1);
				end
			end
			ST_W_SETUP: begin
				if (cntDone) begin
					// Address is valid before the falling edge
					state_nxt = ST_W_PULSE;
					cnt_nxt = CNT_W'(PULSE_CYC - 1);
				end
			end
			ST_W_PULSE: begin
				if (cntDone) begin
					state_nxt = ST_W_HOLD;
					cnt_nxt = CNT_W'(HOLD_CYC - 1);
				end
			end
			ST_W_HOLD: begin
				if (cntDone) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_R_ACCESS: begin
				if (cntDone) begin
					state_nxt = ST_R_DONE;
				end
			end
			ST_R_DONE: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_RESET;
				cnt_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			state_r <= ST_RESET;
			cnt_r <= CNT_W'(RESET_LOW_CYC - 1);
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			cur_r <= '0;
		end else if (accept) begin
			cur_r <= req;
		end
	end

	// Sample in ST_R_DONE; the synchroniser's two cycles come out of the access time
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			rdData_r <= DATA_RESET;
			rdValid_r <= 1'b0;
		end else begin
			rdValid_r <= (state_r == ST_R_DONE);
			if (state_r == ST_R_DONE) begin
				rdData_r <= cur_r.wide ? dqSync_r
					: {8'h00, dqSync_r[7:0]};
			end
		end
	end

	assign rdValid = rdValid_r;
	assign rdData = rdData_r;

	// ****************************************
	// Pin drive
	// ****************************************
	// Pins are flops fed from the next state: same timing as the state,
	// but a strobe can never glitch on a multi-bit decode
	wire nextWrite = (state_nxt == ST_W_SETUP) || (state_nxt == ST_W_PULSE)
		|| (state_nxt == ST_W_HOLD);
	wire nextRead = (state_nxt == ST_R_ACCESS) || (state_nxt == ST_R_DONE);
	wire nextSel = nextWrite || nextRead;
	wire host_req_t cur_nxt = accept ? req : cur_r;
	// Only drive high lanes for word-wide writes
	wire driveHigh = nextWrite && cur_nxt.wide;
	wire driveLow = nextWrite;
	flash_ctl_t ctl_nxt, ctl_r;
	logic [DATA_W-1:0] dqOeN_r;

	// Both enables move together; the device selects on the later edge
	assign ctl_nxt.chipEnable0N = !nextSel;
	assign ctl_nxt.chipEnable1N = !nextSel;
	// Output enable stays high for writes so the write is not overridden
	assign ctl_nxt.outputEnableN = !nextRead;
	assign ctl_nxt.writeEnableN = (state_nxt != ST_W_PULSE);
	assign ctl_nxt.resetPowerdownN = (state_nxt != ST_RESET);
	assign ctl_nxt.byteModeN = cur_nxt.wide;
	// Block and word fields go out unchanged; bit 0 only matters in byte mode
	assign ctl_nxt.addr = nextSel ? cur_nxt.addr
		: ADDR_RESET;

	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			ctl_r <= '{resetPowerdownN: 1'b0, chipEnable0N: 1'b1,
				chipEnable1N: 1'b1, outputEnableN: 1'b1,
				writeEnableN: 1'b1, byteModeN: 1'b0, addr: ADDR_RESET};
			dqOeN_r <= '1;
		end else begin
			ctl_r <= ctl_nxt;
			dqOeN_r <= {{8{!driveHigh}}, {8{!driveLow}}};
		end
	end

	assign ctl = ctl_r;
	assign dqOut = cur_r.data;
	assign dqOeN = dqOeN_r;

	// ****************************************
	// Checks
	// ****************************************
	no_contention_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		!ctl.outputEnableN |-> (dqOeN == 16'hffff))
		else $error("Host drives data while device outputs are on");
	we_oe_excl_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		!ctl.writeEnableN |-> ctl.outputEnableN)
		else $error("Write enable low while output enable low");
	we_select_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		!ctl.writeEnableN |-> !ctl.chipEnable0N && !ctl.chipEnable1N)
		else $error("Write strobe outside selection");
	hold_after_we_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		$rose(ctl.writeEnableN) |-> $stable(ctl.addr) && $stable(dqOut)
		&& !ctl.chipEnable0N)
		else $error("Address or data moved at write enable rise");
	setup_before_we_a: assert property (@(posedge clk)
		disable iff (!rstSync_r)
		$fell(ctl.writeEnableN) |-> $past(!ctl.chipEnable0N)
		&& $stable(ctl.addr))
		else $error("Address not set up at write enable fall");
	recovery_wait_a: assert property (@(posedge clk)
		disable iff (!rstSync_r)
		$rose(ctl.resetPowerdownN) |-> ctl.chipEnable0N [*8])
		else $error("Access during reset recovery");
	byte_high_float_a: assert property (@(posedge clk)
		disable iff (!rstSync_r)
		ctl.byteModeN == 1'b0 |-> dqOeN[15:8] == 8'hff)
		else $error("High lanes driven in byte mode");
	read_done_a: assert property (@(posedge clk) disable iff (!rstSync_r)
		(state_r == ST_R_DONE) |=> rdValid ##1 !rdValid)
		else $error("Read result pulse malformed");

endmodule

// ---- rtl/flash_host_pkg.sv ----
// Package with pin bundles, states and timing constants for the flash host
package flash_host_pkg;

	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	localparam int CLK_PERIOD_NS = 5;

	// Pin phase lengths in ns; minimums round up to whole cycles
	localparam int SETUP_NS = 20;
	localparam int PULSE_NS = 50;
	localparam int HOLD_NS = 10;
	localparam int ACCESS_NS = 120;
	localparam int RESET_LOW_NS = 100;
	localparam int RECOVERY_NS = 1000;

	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_LOW_CYC =
		(RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVERY_CYC =
		(RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int CNT_W = 8;

	// Address field layout
	localparam int BYTE_SEL_BIT = 0;
	localparam int BLOCK_LSB = 16;

	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 21'h000000;

	typedef enum logic [7:0] {
		ST_RESET = 8'h01,
		ST_RECOVER = 8'h02,
		ST_IDLE = 8'h04,
		ST_W_SETUP = 8'h08,
		ST_W_PULSE = 8'h10,
		ST_W_HOLD = 8'h20,
		ST_R_ACCESS = 8'h40,
		ST_R_DONE = 8'h80
	} host_state_t;

	// User request bundle
	typedef struct packed {
		logic write;
		logic wide;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} host_req_t;

	// Pins driven toward the flash
	typedef struct packed {
		logic resetPowerdownN;
		logic chipEnable0N;
		logic chipEnable1N;
		logic outputEnableN;
		logic writeEnableN;
		logic byteModeN;
		logic [ADDR_W-1:0] addr;
	} flash_ctl_t;

endpackage

// ---- test/flash_dev_model.sv ----
// Behavioural flash device answering the host pins
`timescale 1ns/10ps
module flash_dev_model
	import flash_host_pkg::*;
(
	input wire flash_ctl_t ctl,
	input wire logic [DATA_W-1:0] dqOut,
	input wire logic [DATA_W-1:0] dqOeN,
	output logic [DATA_W-1:0] dqIn
);
	// ****
	// Array and lanes
	// ****
	logic [DATA_W-1:0] mem [int];
	logic [DATA_W-1:0] devOut;
	logic [DATA_W-1:0] wd;
	logic [DATA_W-1:0] rd;
	logic flip = 1'b0;
	logic [ADDR_W-1:0] fallAddr = '0;
	wire sel = !ctl.chipEnable0N && !ctl.chipEnable1N;
	wire rdOn = sel && !ctl.outputEnableN && ctl.writeEnableN;
	wire [19:0] wAddr = ctl.addr[20:1];
	wire [DATA_W-1:0] noise = flip ? 16'h5a5a : 16'ha5a5;
	// Floating lanes churn so a stale value never passes
	always #2 flip = ~flip;
	// Address taken at the strobe's fall, as for page buffer writes
	always @(negedge ctl.writeEnableN) fallAddr = ctl.addr;
	// Programs end at the strobe, so a deselect never cuts one short
	always @(posedge ctl.writeEnableN) begin
		if (sel && ctl.outputEnableN
			&& ctl.resetPowerdownN) begin
			wd = mem.exists(wAddr) ? mem[wAddr] : 16'hffff;
			// Lanes come off the pins, so an undriven lane gives noise
			if (ctl.byteModeN) wd = dqIn;
			else if (ctl.addr[0]) wd[15:8] = dqIn[7:0];
			else wd[7:0] = dqIn[7:0];
			// An address that moved under the strobe spoils the word
			if (fallAddr !== ctl.addr) wd = ~wd;
			mem[wAddr] = wd;
		end
	end
	always @* begin
		rd = mem.exists(wAddr) ? mem[wAddr] : 16'hffff;
		if (!ctl.byteModeN) begin
			rd = {noise[15:8], ctl.addr[0] ? rd[15:8] : rd[7:0]};
		end
		devOut = (rdOn && ctl.resetPowerdownN) ? rd : noise;
	end
	assign dqIn = (dqOut & ~dqOeN) | (devOut & dqOeN);
endmodule

// ---- test/flash_host_tb.sv ----
// Self-checking bench for the flash host controller
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	fail_count++; $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module flash_host_tb import flash_host_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic reqValid = 1'b0;
	logic powerDownReq = 1'b0;
	host_req_t req = '0;
	logic reqReady, rdValid;
	logic [DATA_W-1:0] rdData, dqIn, dqOut, dqOeN;
	flash_ctl_t ctl;
	logic [DATA_W-1:0] refMem [int];
	logic [ADDR_W-1:0] pool [8];
	int fail_count = 0;
	int samples_checked = 0;
	always #2.5 clk = ~clk;
	flash_host u_dut (.clk(clk), .rst_n(rst_n), .reqValid(reqValid),
		.reqReady(reqReady), .req(req), .powerDownReq(powerDownReq),
		.rdValid(rdValid), .rdData(rdData), .ctl(ctl), .dqIn(dqIn),
		.dqOut(dqOut), .dqOeN(dqOeN));
	flash_dev_model u_flash (.ctl(ctl), .dqOut(dqOut), .dqOeN(dqOeN),
		.dqIn(dqIn));
	// ****
	// Pin monitor
	// ****
	always @(negedge clk) if (rst_n) begin
		`CHK(ctl.outputEnableN | ctl.writeEnableN, 1'b1)
		`CHK(ctl.chipEnable0N, ctl.chipEnable1N)
		if (!ctl.outputEnableN) `CHK(dqOeN, 16'hffff)
		if (!ctl.byteModeN) `CHK(dqOeN[15:8], 8'hff)
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic timed_out;
		fail_count++;
		$display("MISMATCH %0t wait expired", $time);
		stop_test();
	endtask
	task automatic wait_ready(output int n);
		n = 0;
		while (reqReady !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > 1000) timed_out();
		end
	endtask
	function automatic logic [DATA_W-1:0] expect_rd(
		input logic [ADDR_W-1:0] a, input logic wide);
		logic [DATA_W-1:0] w;
		w = refMem.exists(a[20:1]) ? refMem[a[20:1]] : 16'hffff;
		if (wide) return w;
		return {8'h00, a[0] ? w[15:8] : w[7:0]};
	endfunction
	// ****
	// Requests
	// ****
	task automatic op(input logic w, wide, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		int n;
		logic [DATA_W-1:0] m;
		@(negedge clk);
		wait_ready(n);
		@(posedge clk);
		reqValid <= 1'b1;
		req <= '{w, wide, a, d};
		@(posedge clk);
		reqValid <= 1'b0;
		if (w) begin
			m = expect_rd(a, 1'b1);
			if (wide) m = d;
			else if (a[0]) m[15:8] = d[7:0];
			else m[7:0] = d[7:0];
			refMem[a[20:1]] = m;
		end else begin
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (rdValid !== 1'b1 && n < 100);
			if (n >= 100) timed_out();
			`CHK(rdData, expect_rd(a, wide))
		end
	endtask
	task automatic power_cycle;
		int n;
		@(posedge clk);
		powerDownReq <= 1'b1;
		repeat (30) @(posedge clk);
		@(negedge clk);
		`CHK(ctl.resetPowerdownN, 1'b0)
		@(posedge clk);
		powerDownReq <= 1'b0;
		@(negedge clk);
		wait_ready(n);
		`CHK(n >= RECOVERY_CYC, 1'b1)
	endtask
	initial begin
		int n;
		void'($urandom(32'hec62202a));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		wait_ready(n);
		`CHK(n >= RESET_LOW_CYC + RECOVERY_CYC, 1'b1)
		pool[0] = 21'h000000;
		pool[1] = 21'h000001;
		pool[2] = 21'h1fffff;
		for (int k = 3; k < 8; k++) pool[k] = ADDR_W'($urandom);
		// Byte lanes then a word read that ignores the low bit
		op(1'b1, 1'b0, 21'h000001, 16'h00c3);
		op(1'b1, 1'b0, 21'h000000, 16'h003c);
		op(1'b0, 1'b1, 21'h000001, 16'h0000);
		op(1'b1, 1'b1, 21'h1fffff, 16'hbeef);
		op(1'b0, 1'b0, 21'h1fffff, 16'h0000);
		for (int i = 0; i < 60; i++) begin
			if (i == 30) power_cycle();
			op(1'($urandom), 1'($urandom), pool[$urandom_range(7, 0)],
				DATA_W'($urandom));
		end
		stop_test();
	end
endmodule
